/* File: src/sar_ctrl_consts.svh */
/*
  constants of the converter control block: timing, register map, fields.
  assumes the includer supplies nothing; definitions only.
*/
`ifndef SAR_CTRL_CONSTS_SVH
`define SAR_CTRL_CONSTS_SVH

// ==========================================
// timing
`define CLK_NS          20
`define CONV_NS         300
`define ACQ_NS          40
`define LIGHT_WAKE_NS   300
`define DEEP_EXT_US     80
`define DEEP_INT_MS     500
// least times round up to whole cycles
`define CONV_CYC  ((`CONV_NS + `CLK_NS - 1) / `CLK_NS)
`define ACQ_CYC   ((`ACQ_NS + `CLK_NS - 1) / `CLK_NS)
`define LIGHT_CYC ((`LIGHT_WAKE_NS + `CLK_NS - 1) / `CLK_NS)
`define DEXT_CYC  ((`DEEP_EXT_US * 1000 + `CLK_NS - 1) / `CLK_NS)
`define DINT_CYC  ((`DEEP_INT_MS * 1000000 + `CLK_NS - 1) / `CLK_NS)
`define CNT_W     25

// ==========================================
// register map (byte addresses)
`define A_OFFSET    8'h00
`define A_STATUS    8'h04
`define A_RESULT    8'h08
`define A_IRQ_STAT  8'h0c
`define A_IRQ_MASK  8'h10

// ==========================================
// codes and fields
`define OFF_MAX     10'sh147
`define OFF_MIN     10'sh2b9
`define FULL_CODE   15'sh0fff
`define ZERO_CODE   12'h000
`define ONES_CODE   12'hfff
`define OFF_RST     10'h000
`define EV_DONE     0
`define EV_OVR      1
`define EV_IGN      2
`define EV_W        3
`endif

/* File: src/sar_ctrl_pkg.sv */
/*
  types of the converter control block.
  assumes nothing; it uses no macro of sar_ctrl_consts.svh.
*/
package sar_ctrl_pkg;
  typedef enum logic [2:0] {
    ST_TRACK, ST_CONV, ST_ACQ, ST_SLEEP, ST_WAKE
  } conv_state_t;

  // output word: top bit overrange, next sign, then data
  typedef struct packed {
    logic        ovr;
    logic        sign;
    logic [10:0] data;
  } res_t;
endpackage

/* File: src/sar_adc_conversion_control.sv */
/*
  control of a 12-bit successive-approximation converter: start edge,
  conversion and acquisition timing, sleep modes with wake-up delays,
  offset add, saturation and overrange, apb registers and interrupt.
  assumes pclk at 50 mhz, an apb master, and the raw sar code on
  raw_code as a signed count of lsbs from the analog side.
*/
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`include "sar_ctrl_consts.svh"

module sar_adc_conversion_control
  import sar_ctrl_pkg::*;
#(
  parameter logic [`CNT_W-1:0] DEEP_INT_WAKE = `CNT_W'(`DINT_CYC)
) (
  // clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // converter pins
  input  wire logic               convert_start_n,
  input  wire logic               light_sleep_request,
  input  wire logic               deep_sleep_request,
  input  wire logic               saturate_enable,
  input  wire logic               internal_ref_select,
  input  wire logic signed [13:0] raw_code,
  // result and state
  output logic [10:0]             conv_data,
  output logic                    range_sign_bit,
  output logic                    overrange_bit,
  output logic                    busy,
  output logic                    irq
);

  // ==========================================
  // pin synchronisers
  logic [4:0]  pin_m_r, pin_s_r;
  logic [13:0] raw_m_r, raw_s_r;
  logic        cs_d_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_m_r <= 5'h01;
      pin_s_r <= 5'h01;
      raw_m_r <= 14'h0000;
      raw_s_r <= 14'h0000;
      cs_d_r  <= 1'b1;
    end else begin
      pin_m_r <= {internal_ref_select, saturate_enable,
                  deep_sleep_request, light_sleep_request,
                  convert_start_n};
      pin_s_r <= pin_m_r;
      raw_m_r <= raw_code;
      raw_s_r <= raw_m_r;
      cs_d_r  <= pin_s_r[0];
    end
  end

  logic start_fall, lsleep, dsleep, sat, int_ref;
  assign start_fall = cs_d_r & ~pin_s_r[0];
  assign lsleep     = pin_s_r[1];
  assign dsleep     = pin_s_r[2];
  assign sat        = pin_s_r[3];
  assign int_ref    = pin_s_r[4];

  // ==========================================
  // conversion sequencer
  conv_state_t            st_r, st_nxt;
  logic [`CNT_W-1:0]      cnt_r, cnt_nxt;
  logic                   deep_r, deep_nxt;
  logic signed [13:0]     smp_r, smp_nxt;
  res_t                   res_r, res_nxt;
  logic                   busy_r, busy_nxt;
  logic signed [9:0]      off_r, off_nxt;
  logic signed [14:0]     sum_w;
  logic                   oor_w, conv_end, ign_ev;
  logic [11:0]            clamp_w;

  // sum is one bit wider than the wider term, so it cannot wrap
  assign sum_w = {smp_r[13], smp_r} + {{5{off_r[9]}}, off_r};
  assign oor_w = sum_w[14] | (sum_w > `FULL_CODE);
  assign clamp_w = sum_w[14] ? `ZERO_CODE :
                   (sum_w > `FULL_CODE) ? `ONES_CODE : sum_w[11:0];
  assign conv_end = (st_r == ST_CONV) && (cnt_r == '0);

  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = (cnt_r == '0) ? cnt_r : cnt_r - 1'b1;
    deep_nxt = deep_r;
    smp_nxt  = smp_r;
    res_nxt  = res_r;
    ign_ev   = 1'b0;
    case (st_r)
      ST_TRACK: begin
        if (lsleep | dsleep) begin
          st_nxt   = ST_SLEEP;
          deep_nxt = dsleep;
          ign_ev   = start_fall;
        end else if (start_fall) begin
          st_nxt  = ST_CONV;
          smp_nxt = raw_s_r;
          cnt_nxt = `CNT_W'(`CONV_CYC - 1);
        end
      end
      ST_CONV: begin
        ign_ev = start_fall;
        if (cnt_r == '0) begin
          st_nxt  = ST_ACQ;
          cnt_nxt = `CNT_W'(`ACQ_CYC - 1);
          if (sat) begin
            res_nxt = {oor_w, clamp_w};
          end else begin
            res_nxt = {oor_w, sum_w[11:0]};
          end
        end
      end
      ST_ACQ: begin
        // an early start would sample an unsettled input
        ign_ev = start_fall;
        if (cnt_r == '0) begin
          st_nxt = ST_TRACK;
        end
      end
      ST_SLEEP: begin
        ign_ev = start_fall;
        deep_nxt = deep_r | dsleep;
        if (!(lsleep | dsleep)) begin
          st_nxt = ST_WAKE;
          if (!deep_r) begin
            cnt_nxt = `CNT_W'(`LIGHT_CYC - 1);
          end else if (int_ref) begin
            cnt_nxt = DEEP_INT_WAKE - 1'b1;
          end else begin
            cnt_nxt = `CNT_W'(`DEXT_CYC - 1);
          end
        end
      end
      ST_WAKE: begin
        ign_ev = start_fall;
        if (lsleep | dsleep) begin
          st_nxt   = ST_SLEEP;
          deep_nxt = dsleep;
        end else if (cnt_r == '0) begin
          st_nxt = ST_TRACK;
        end
      end
      default: begin
        st_nxt = ST_TRACK;
      end
    endcase
    busy_nxt = (st_nxt == ST_CONV);
  end

  // reset aborts any conversion in flight
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r   <= ST_TRACK;
      cnt_r  <= '0;
      deep_r <= 1'b0;
      smp_r  <= 14'sh0000;
      res_r  <= '0;
      busy_r <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      deep_r <= deep_nxt;
      smp_r  <= smp_nxt;
      res_r  <= res_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign conv_data      = res_r.data;
  assign range_sign_bit = res_r.sign;
  assign overrange_bit  = res_r.ovr;
  assign busy           = busy_r;

  // ==========================================
  // apb registers and interrupt
  logic [31:0]       rd_nxt, rd_r;
  logic              rdy_r, err_r, err_nxt;
  logic [`EV_W-1:0]  stat_r, stat_nxt, mask_r, mask_nxt, ev_w;
  logic              irq_r, irq_nxt;
  logic              setup, acc, wr, bad_off;

  assign setup = psel & ~penable;
  assign acc   = psel & penable & rdy_r;
  assign wr    = acc & pwrite;
  // reserved bits 12:10 must be zero and the value within +-327
  assign bad_off = (pwdata[12:10] != 3'h0) ||
                   (!pwdata[9] && ($signed(pwdata[9:0]) > `OFF_MAX)) ||
                   (pwdata[9] && ($signed(pwdata[9:0]) < `OFF_MIN));
  assign ev_w = {ign_ev, conv_end & oor_w, conv_end};

  always_comb begin
    rd_nxt   = 32'h0000_0000;
    err_nxt  = 1'b0;
    off_nxt  = off_r;
    mask_nxt = mask_r;
    stat_nxt = stat_r;
    case (paddr)
      `A_OFFSET: begin
        rd_nxt  = {22'h0, off_r};
        err_nxt = pwrite & bad_off;
      end
      `A_STATUS:   rd_nxt = {27'h0, int_ref, st_r == ST_WAKE,
                             st_r == ST_SLEEP, st_r == ST_ACQ, busy_r};
      `A_RESULT:   rd_nxt = {19'h0, res_r};
      `A_IRQ_STAT: rd_nxt = {29'h0, stat_r};
      `A_IRQ_MASK: rd_nxt = {29'h0, mask_r};
      default:     err_nxt = 1'b1;
    endcase
    if (wr && paddr == `A_OFFSET && !bad_off) begin
      off_nxt = pwdata[9:0];
    end
    if (wr && paddr == `A_IRQ_MASK) begin
      mask_nxt = pwdata[`EV_W-1:0];
    end
    if (acc && !pwrite && paddr == `A_IRQ_STAT) begin
      stat_nxt = '0;
    end
    // a new event wins over the read that clears
    stat_nxt = stat_nxt | ev_w;
    irq_nxt  = |(stat_nxt & mask_nxt);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_r   <= 32'h0000_0000;
      rdy_r  <= 1'b0;
      err_r  <= 1'b0;
      off_r  <= `OFF_RST;
      mask_r <= '0;
      stat_r <= '0;
      irq_r  <= 1'b0;
    end else begin
      // no wait state: answer is ready in the first access cycle
      rdy_r  <= setup;
      rd_r   <= setup ? rd_nxt : rd_r;
      err_r  <= setup ? err_nxt : 1'b0;
      off_r  <= off_nxt;
      mask_r <= mask_nxt;
      stat_r <= stat_nxt;
      irq_r  <= irq_nxt;
    end
  end

  assign prdata  = rd_r;
  assign pready  = rdy_r;
  assign pslverr = err_r;
  assign irq     = irq_r;

  // ==========================================
  // checks
  localparam int CONV_C = `CONV_CYC;
  logic [7:0] blen_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blen_r <= 8'h00;
    end else begin
      blen_r <= busy_r ? blen_r + 8'h01 : 8'h00;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_start_hold: assert property (
    (st_r == ST_TRACK && start_fall && !lsleep && !dsleep)
      |=> busy_r && smp_r == $past(raw_s_r))
    else $error("start edge did not begin a conversion");
  a_conv_len: assert property (
    $fell(busy_r) |-> int'(blen_r) == CONV_C)
    else $error("conversion length wrong");
  a_acq_phase: assert property (
    $fell(busy_r) |-> st_r == ST_ACQ ##1 st_r == ST_ACQ
      ##1 st_r != ST_ACQ)
    else $error("acquisition phase length wrong");
  a_sleep_block: assert property (
    (lsleep || dsleep) && st_r != ST_CONV |=> !busy_r)
    else $error("conversion started while asleep");
  a_wake_block: assert property (
    st_r == ST_WAKE && cnt_r != '0 |=> !busy_r)
    else $error("conversion started before wake-up");
  a_sat_clamp: assert property (
    conv_end && sat && sum_w > `FULL_CODE |=>
      {res_r.sign, res_r.data} == `ONES_CODE && res_r.ovr)
    else $error("saturated high code wrong");
  a_sat_floor: assert property (
    conv_end && sat && sum_w[14] |=>
      {res_r.sign, res_r.data} == `ZERO_CODE && res_r.ovr)
    else $error("saturated low code wrong");
  a_offset_add: assert property (
    conv_end && !sat |=> {res_r.sign, res_r.data} == $past(sum_w[11:0])
      && res_r.ovr == $past(oor_w))
    else $error("offset sum not output");
  a_offset_hold: assert property (
    !(wr && paddr == `A_OFFSET && !bad_off) |=> $stable(off_r))
    else $error("offset changed without a valid write");
  a_ignore_busy: assert property (
    st_r == ST_CONV && start_fall |=>
      stat_r[`EV_IGN] && (busy_r || st_r == ST_ACQ))
    else $error("start during conversion not ignored");

  c_conv_done: cover property (conv_end ##3 st_r == ST_TRACK);
  c_overrange: cover property (conv_end && oor_w && !sat);
  c_deep_wake: cover property (st_r == ST_WAKE && deep_r ##1
                               st_r == ST_TRACK);
  c_irq_clear: cover property ($fell(irq_r));

endmodule

/* File: verification/conv_host_model.sv */
/*
  controller model: issues convert-start pulses and presents the raw
  sar code. assumes busy comes from the converter control block.
*/
`timescale 1ns/1ns
module conv_host_model (
  // clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // bench side
  input  wire logic               go,
  input  wire logic               rude,
  input  wire logic signed [13:0] raw_in,
  output logic                    ready,
  // converter side
  input  wire logic               busy,
  output logic                    convert_start_n,
  output logic signed [13:0]      raw_code
);
  logic [2:0] idle_r;
  logic [2:0] low_r;
  // ====================
  // start pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_r          <= 3'h0;
      low_r           <= 3'h0;
      convert_start_n <= 1'b1;
      raw_code        <= 14'sh0000;
    end else begin
      idle_r <= (busy || go) ? 3'h0 : idle_r + {2'h0, idle_r != 3'h7};
      if (go && (ready || rude)) begin
        low_r           <= 3'h3;
        convert_start_n <= 1'b0;
        raw_code        <= raw_in;
      end else if (low_r != 3'h0) begin
        low_r           <= low_r - 3'h1;
        convert_start_n <= (low_r == 3'h1);
      end
    end
  end
  // rude starts break the acquisition wait on purpose
  assign ready = !busy && idle_r >= 3'h5 && low_r == 3'h0;
endmodule

/* File: verification/test_sar_adc_conversion_control.sv */
/*
  self-checking bench of the converter control block.
  assumes the package and constants header of the design.
*/
`timescale 1ns/1ns
`include "sar_ctrl_consts.svh"
module test_sar_adc_conversion_control;
  import sar_ctrl_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, busy, irq, sign, ovr, ready, cs_n;
  logic go = 0, rude = 0, lsr = 0, dsr = 0, sat = 0, iref = 0, bq = 0;
  logic signed [13:0] raw_in = 14'sh0, raw;
  logic [10:0] data;
  logic [12:0] exp_q[$];
  int errors = 0, num_checks = 0, bcnt = 0, i, off;
  sar_adc_conversion_control #(.DEEP_INT_WAKE(25'd50)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .convert_start_n(cs_n),
    .light_sleep_request(lsr), .deep_sleep_request(dsr),
    .saturate_enable(sat), .internal_ref_select(iref), .raw_code(raw),
    .conv_data(data), .range_sign_bit(sign), .overrange_bit(ovr),
    .busy(busy), .irq(irq));
  conv_host_model i_host (.pclk(pclk), .presetn(presetn), .go(go),
    .rude(rude), .raw_in(raw_in), .ready(ready), .busy(busy),
    .convert_start_n(cs_n), .raw_code(raw));
  always #10 pclk = ~pclk;
  // ====================
  // checking
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out;
    if (errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  function automatic logic [12:0] expect_res(int r, int o, bit s);
    int v;
    v = r + o;
    if (!s)
      return {v < 0 || v > 4095, v[11:0]};
    return {v < 0 || v > 4095,
            v < 0 ? 12'h000 : v > 4095 ? 12'hfff : v[11:0]};
  endfunction
  // results pop the oldest note when busy falls
  always @(negedge pclk) begin
    if (busy)
      bcnt++;
    // a reset cuts a conversion short: no result is due then
    if (!presetn)
      bcnt = 0;
    if (bq && !busy && presetn) begin
      check("busy length", `CONV_CYC, bcnt);
      bcnt = 0;
      if (exp_q.size() == 0)
        check("extra result", 0, 1);
      else
        check("result", exp_q.pop_front(), {ovr, sign, data});
    end
    bq = busy;
  end
  // ====================
  // drivers
  task automatic apb(bit wr, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // read right after the edge: the values that the edge sampled
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(logic [7:0] a, logic [31:0] e, bit ee);
    apb(0, a, 32'h0);
    check("read data", e, rd);
    check("slave error", ee, err);
  endtask
  task automatic poke;
    @(posedge pclk);
    go <= 1'b1;
    rude <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    rude <= 1'b0;
  endtask
  task automatic conv(int r, int o, bit s, bit twice);
    // waits are ended by the watchdog only
    while (ready !== 1'b1) @(negedge pclk);
    @(posedge pclk);
    sat <= s;
    raw_in <= 14'(r);
    go <= 1'b1;
    exp_q.push_back(expect_res(r, o, s));
    @(posedge pclk);
    go <= 1'b0;
    while (busy !== 1'b1) @(negedge pclk);
    if (twice)
      poke();
    while (busy !== 1'b0) @(negedge pclk);
  endtask
  // ====================
  // tests
  initial begin
    void'($urandom(31));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(`A_OFFSET, 32'h0, 0);
    rdchk(8'h14, 32'h0, 1);
    apb(1, `A_OFFSET, 32'h148);
    check("offset refused", 1, err);
    apb(1, `A_OFFSET, 32'h400);
    check("offset refused", 1, err);
    rdchk(`A_OFFSET, 32'h0, 0);
    conv(-1, 0, 1, 0);
    conv(4096, 0, 1, 0);
    conv(4095, 0, 1, 0);
    conv(-1, 0, 0, 0);
    conv(4096, 0, 0, 0);
    rdchk(`A_RESULT, 32'h1000, 0);
    for (i = 0; i < 12; i++) begin
      off = i == 0 ? 327 : i == 1 ? -327 : $urandom_range(654) - 327;
      apb(1, `A_OFFSET, 32'(off) & 32'h3ff);
      check("offset accepted", 0, err);
      conv($urandom_range(4700) - 400, off, i[0], 0);
    end
    apb(1, `A_OFFSET, 32'h0);
    apb(1, `A_IRQ_MASK, 32'h1);
    apb(0, `A_IRQ_STAT, 32'h0);
    conv(100, 0, 1, 1);
    repeat (2) @(negedge pclk);
    check("irq raised", 1, irq);
    rdchk(`A_IRQ_STAT, 32'h5, 0);
    repeat (2) @(negedge pclk);
    check("irq cleared", 0, irq);
    apb(1, `A_IRQ_MASK, 32'h0);
    conv(200, 0, 1, 0);
    repeat (2) @(negedge pclk);
    check("irq masked", 0, irq);
    rdchk(`A_IRQ_STAT, 32'h1, 0);
    lsr <= 1'b1; // light sleep only with the external reference
    repeat (3) @(posedge pclk);
    poke();
    repeat (8) @(posedge pclk);
    lsr <= 1'b0;
    repeat (4) @(posedge pclk);
    poke();
    rdchk(`A_IRQ_STAT, 32'h4, 0);
    repeat (20) @(posedge pclk);
    conv(300, 0, 1, 0);
    @(posedge pclk);
    dsr <= 1'b1;
    repeat (4) @(posedge pclk);
    dsr <= 1'b0;
    repeat (4010) @(posedge pclk);
    conv(400, 0, 0, 0);
    @(posedge pclk);
    iref <= 1'b1;
    dsr <= 1'b1;
    repeat (4) @(posedge pclk);
    dsr <= 1'b0;
    repeat (10) @(posedge pclk);
    rdchk(`A_STATUS, 32'h18, 0);
    repeat (50) @(posedge pclk);
    conv(500, 0, 0, 0);
    // reset in mid-conversion: no result, offset back to zero
    apb(1, `A_OFFSET, 32'h10);
    poke();
    repeat (6) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check("busy after reset", 0, busy);
    rdchk(`A_OFFSET, 32'h0, 0);
    rdchk(`A_STATUS, 32'h10, 0);
    conv(600, 0, 1, 0);
    repeat (30) @(posedge pclk);
    check("results left", 0, exp_q.size());
    close_out();
  end
  initial begin
    repeat (30000) @(posedge pclk);
    errors++;
    close_out();
  end
endmodule
